// ---- rtl/i2cm_map.svh ----
// Register offsets, field positions and reset values of the two-wire master controller
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH

// ----------------------------------------
// Register byte offsets on the APB port
// ----------------------------------------
`define I2CM_OFF_CTRL 8'h00
`define I2CM_OFF_TAR 8'h04
`define I2CM_OFF_CMD 8'h10
`define I2CM_OFF_FHCNT 8'h1C
`define I2CM_OFF_FLCNT 8'h20
`define I2CM_OFF_ENABLE 8'h6C
`define I2CM_OFF_STATUS 8'h70
`define I2CM_OFF_ABN_SRC 8'h80
`define I2CM_OFF_EN_STAT 8'h9C
`define I2CM_OFF_SPK_SF 8'hA0
`define I2CM_OFF_SPK_HS 8'hA4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define I2CM_CTRL_MASTER 0
`define I2CM_TAR_TEN 12
`define I2CM_CMD_RW 8
`define I2CM_CMD_STOP 9
`define I2CM_EN_BIT 0
`define I2CM_ABORT_BIT 1
`define I2CM_SPEED_HS 2'b11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define I2CM_RST_CTRL 7'h7F
`define I2CM_RST_TAR 13'h1055
`define I2CM_RST_FHCNT 16'h003C
`define I2CM_RST_FLCNT 16'h0082
`define I2CM_RST_SPK_SF 8'h05
`define I2CM_RST_SPK_HS 8'h01
`define I2CM_SPK_MIN 8'h01

`endif

// ---- rtl/i2cm_pkg.sv ----
// Types shared by the two-wire master controller
package i2cm_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_STOP} i2cm_state_type;
    typedef enum logic [1:0] {PH_HDR, PH_LO, PH_DATA} i2cm_phase_type;
endpackage

// ---- rtl/i2cm_spike_filter.sv ----
// Glitch filter for one synchronised bus line
`timescale 1ns/1ps
module i2cm_spike_filter #(
    parameter int LW = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic din,
    input wire logic [LW-1:0] limit,
    output logic dout
);
    logic din_q;
    logic run_q;
    logic [LW-1:0] cnt_q;
    logic dout_q;

    // ----------------------------------------
    // Change detection and limit test
    // ----------------------------------------
    wire change = din != din_q;
    wire at_limit = run_q & (cnt_q >= limit);

    // Counter starts on a change, a second change cancels it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            din_q <= 1'b1;
            run_q <= 1'b0;
            cnt_q <= '0;
            dout_q <= 1'b1;
        end else begin
            din_q <= din;
            if (change) begin
                run_q <= ~run_q;
                cnt_q <= run_q ? '0 : LW'(1);
            end else if (at_limit) begin
                dout_q <= din;
                run_q <= 1'b0;
                cnt_q <= '0;
            end else if (run_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign dout = dout_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_filter_start;
        @(posedge ref_clk) disable iff (rst) (change && !run_q) |=> (run_q && cnt_q == LW'(1));
    endproperty
    a_filter_start: assert property (p_filter_start) else $error("filter did not start on change");

    property p_filter_take;
        @(posedge ref_clk) disable iff (rst) (at_limit && !change) |=> (dout == $past(din) && !run_q);
    endproperty
    a_filter_take: assert property (p_filter_take) else $error("filter missed stable input");

    property p_filter_cancel;
        @(posedge ref_clk) disable iff (rst) (change && run_q) |=> ($stable(dout) && !run_q && cnt_q == '0);
    endproperty
    a_filter_cancel: assert property (p_filter_cancel) else $error("filter passed a spike");
endmodule

// ---- rtl/i2cm_cmd_buf.sv ----
// Small command buffer with valid/ready on both sides
`timescale 1ns/1ps
module i2cm_cmd_buf #(
    parameter int W = 10,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;

    // ----------------------------------------
    // Handshake terms; depth must be a power of two
    // ----------------------------------------
    assign in_ready = count_q != CW'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data = mem_q[rd_ptr_q];
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Storage written only on push, so no reset needed for it
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level; flush empties in one edge
    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_flush_empties;
        @(posedge ref_clk) disable iff (rst) flush |=> !out_valid;
    endproperty
    a_flush_empties: assert property (p_flush_empties) else $error("flush left entries");
endmodule

// ---- rtl/i2cm_ctrl.sv ----
// Two-wire bus master controller with APB registers, command queue and glitch filters
`timescale 1ns/1ps
`include "i2cm_map.svh"
module i2cm_ctrl #(
    parameter bit LIVE_TARGET_REWRITE = 1'b1,
    parameter bit EMPTY_QUEUE_HOLD = 1'b1,
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output i2cm_pkg::i2cm_state_type state
);
    import i2cm_pkg::*;

    logic [6:0] ctrl_q;
    logic [12:0] tar_q;
    logic [15:0] fh_q;
    logic [15:0] fl_q;
    logic [7:0] spk_sf_q;
    logic [7:0] spk_hs_q;
    logic en_q;
    logic abort_q;
    logic [1:0] abn_q;
    logic [7:0] rx_data_q;
    logic rx_valid_q;
    logic [31:0] prdata_q;
    logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
    logic scl_f, sda_f;
    i2cm_state_type state_q;
    i2cm_phase_type phase_q;
    logic [1:0] step_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic [7:0] rxsh_q;
    logic [15:0] cnt_q;
    logic cur_rw_q, cur_stop_q;
    logic [7:0] cur_data_q;
    logic scl_oe_q, sda_oe_q;
    logic sda_hold_q;
    logic buf_in_ready, buf_out_valid;
    logic [9:0] buf_out_data;

    // ----------------------------------------
    // Line synchronisers and glitch filters
    // ----------------------------------------
    // Two flops before any logic reads the pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q} <= 4'hF;
        end else begin
            {scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q} <= {scl_i, scl_s1_q, sda_i, sda_s1_q};
        end
    end

    // High-speed limit only in speed mode 3
    wire [7:0] spk_lim = (ctrl_q[2:1] == `I2CM_SPEED_HS) ? spk_hs_q : spk_sf_q;

    i2cm_spike_filter #(.LW(8)) u_scl_filt (
        .ref_clk(ref_clk), .rst(rst), .din(scl_s2_q), .limit(spk_lim), .dout(scl_f)
    );
    i2cm_spike_filter #(.LW(8)) u_sda_filt (
        .ref_clk(ref_clk), .rst(rst), .din(sda_s2_q), .limit(spk_lim), .dout(sda_f)
    );

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire [7:0] ad = 8'(paddr);
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_ctrl = ad == `I2CM_OFF_CTRL;
    wire hit_tar = ad == `I2CM_OFF_TAR;
    wire hit_cmd = ad == `I2CM_OFF_CMD;
    wire hit_fh = ad == `I2CM_OFF_FHCNT;
    wire hit_fl = ad == `I2CM_OFF_FLCNT;
    wire hit_en = ad == `I2CM_OFF_ENABLE;
    wire hit_st = ad == `I2CM_OFF_STATUS;
    wire hit_abn = ad == `I2CM_OFF_ABN_SRC;
    wire hit_ens = ad == `I2CM_OFF_EN_STAT;
    wire hit_sf = ad == `I2CM_OFF_SPK_SF;
    wire hit_hs = ad == `I2CM_OFF_SPK_HS;
    wire mapped = |{hit_ctrl, hit_tar, hit_cmd, hit_fh, hit_fl, hit_en, hit_st, hit_abn, hit_ens, hit_sf, hit_hs};
    wire cmd_push = access & pwrite & hit_cmd & en_q;
    wire wr = access & pwrite & pready & mapped;
    wire rd = access & ~pwrite & mapped;
    wire [7:0] spk_wval = (pwdata[7:0] < `I2CM_SPK_MIN) ? `I2CM_SPK_MIN : pwdata[7:0];
    wire busy = state_q != ST_IDLE;
    wire en_status = en_q | busy;
    wire [5:0] status = {busy, 1'b0, rx_valid_q, ~buf_out_valid, buf_in_ready, en_status};

    // A full queue stretches the access instead of dropping the command
    assign pready = ~cmd_push | buf_in_ready;
    assign pslverr = access & ~mapped;

    // Read selection
    wire [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl_q} : hit_tar ? {19'h0, tar_q} :
        hit_cmd ? {24'h0, rx_data_q} : hit_fh ? {16'h0, fh_q} : hit_fl ? {16'h0, fl_q} :
        hit_en ? {30'h0, abort_q, en_q} : hit_st ? {26'h0, status} : hit_abn ? {30'h0, abn_q} :
        hit_ens ? {31'h0, en_status} : hit_sf ? {24'h0, spk_sf_q} : hit_hs ? {24'h0, spk_hs_q} : 32'h0;

    // Read data captured in the setup phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    // ----------------------------------------
    // Engine control terms
    // ----------------------------------------
    wire master = ctrl_q[`I2CM_CTRL_MASTER];
    wire hi_wait = (step_q == 2'd1) & (state_q == ST_BIT || state_q == ST_START || state_q == ST_STOP);
    wire tick = (cnt_q == 16'h0) & (~hi_wait | scl_f);
    wire stop_now = abort_q | ~en_q;
    wire byte_end = (state_q == ST_BIT) & (step_q == 2'd1) & tick & (bit_q == 4'd8);
    wire addr_nack = byte_end & (phase_q != PH_DATA) & sda_f;
    wire data_end = byte_end & (phase_q == PH_DATA);
    wire go_idle = (state_q == ST_IDLE) & en_q & master & ~abort_q & buf_out_valid;
    wire go_next = ((data_end & ~cur_stop_q) | (state_q == ST_HOLD)) & ~stop_now & buf_out_valid;
    wire pop = go_idle | go_next;
    wire next_rw = buf_out_data[`I2CM_CMD_RW];
    wire abort_done = (state_q == ST_IDLE) & abort_q;
    wire flush = ~en_q | abort_done;
    wire [7:0] hdr = tar_q[`I2CM_TAR_TEN] ? {5'b11110, tar_q[9:8], cur_rw_q} : {tar_q[6:0], cur_rw_q};

    // Write data go out with a released ack slot, reads release and ack unless last
    function automatic logic [8:0] byte_of(input logic [9:0] c);
        byte_of = c[`I2CM_CMD_RW] ? {8'hFF, c[`I2CM_CMD_STOP]} : {c[7:0], 1'b1};
    endfunction
    wire [8:0] next_byte = byte_of(buf_out_data);

    i2cm_cmd_buf #(.W(10), .DEPTH(2)) u_cmd_buf (
        .ref_clk(ref_clk), .rst(rst), .flush(flush),
        .in_valid(cmd_push), .in_ready(buf_in_ready), .in_data(pwdata[9:0]),
        .out_valid(buf_out_valid), .out_ready(pop), .out_data(buf_out_data)
    );

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Configuration; target may follow the engine live only if built so
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q <= `I2CM_RST_CTRL;
            tar_q <= `I2CM_RST_TAR;
            fh_q <= `I2CM_RST_FHCNT;
            fl_q <= `I2CM_RST_FLCNT;
            spk_sf_q <= `I2CM_RST_SPK_SF;
            spk_hs_q <= `I2CM_RST_SPK_HS;
            en_q <= 1'b0;
        end else if (wr) begin
            if (hit_ctrl && !en_q) ctrl_q <= pwdata[6:0];
            if (hit_tar && (!en_q || LIVE_TARGET_REWRITE)) tar_q <= pwdata[12:0];
            if (hit_fh && !en_q) fh_q <= pwdata[15:0];
            if (hit_fl && !en_q) fl_q <= pwdata[15:0];
            if (hit_sf && !en_q) spk_sf_q <= spk_wval;
            if (hit_hs && !en_q) spk_hs_q <= spk_wval;
            if (hit_en) en_q <= pwdata[`I2CM_EN_BIT];
        end
    end

    // Abort request, cause flags and receive byte; a hardware set beats a clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            abort_q <= 1'b0;
            abn_q <= 2'b00;
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else begin
            if (abort_done) begin
                abort_q <= 1'b0;
            end else if (wr && hit_en && pwdata[`I2CM_ABORT_BIT] && en_q && master) begin
                abort_q <= 1'b1;
            end
            abn_q <= (abn_q & ~((rd && hit_abn) ? prdata_q[1:0] : 2'b00)) | {abort_done, addr_nack};
            rx_valid_q <= (data_end && cur_rw_q) | (rx_valid_q & ~(rd && hit_cmd));
            if (data_end && cur_rw_q) rx_data_q <= rxsh_q;
        end
    end

    // ----------------------------------------
    // Bus engine
    // ----------------------------------------
    // Step 0 drives SCL low, step 1 waits out the high phase with stretching
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            phase_q <= PH_HDR;
            step_q <= 2'd0;
            bit_q <= 4'd0;
            sh_q <= 9'h1FF;
            rxsh_q <= 8'h00;
            cnt_q <= 16'h0;
            cur_rw_q <= 1'b0;
            cur_stop_q <= 1'b0;
            cur_data_q <= 8'h00;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            if (!tick && cnt_q != 16'h0 && (!hi_wait || scl_f)) cnt_q <= cnt_q - 16'h1;
            if (pop) begin
                cur_rw_q <= next_rw;
                cur_stop_q <= buf_out_data[`I2CM_CMD_STOP];
                cur_data_q <= buf_out_data[7:0]; // Head moves on at pop, keep the byte
            end
            unique case (state_q)
                ST_IDLE: begin
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    if (go_idle) begin
                        state_q <= ST_START;
                        step_q <= 2'd1;
                        cnt_q <= fh_q;
                    end
                end
                ST_START: if (tick) begin
                    cnt_q <= (step_q == 2'd2) ? fl_q : fh_q;
                    step_q <= (step_q == 2'd2) ? 2'd0 : step_q + 2'd1;
                    if (step_q == 2'd0) scl_oe_q <= 1'b0;
                    if (step_q == 2'd1) sda_oe_q <= 1'b1;
                    if (step_q == 2'd2) begin
                        scl_oe_q <= 1'b1;
                        state_q <= ST_BIT;
                        phase_q <= PH_HDR;
                        bit_q <= 4'd0;
                        sh_q <= {hdr, 1'b1};
                        sda_oe_q <= ~hdr[7];
                    end
                end
                ST_BIT: if (tick && step_q == 2'd0) begin
                    scl_oe_q <= 1'b0;
                    step_q <= 2'd1;
                    cnt_q <= fh_q;
                end else if (tick) begin
                    scl_oe_q <= 1'b1;
                    step_q <= 2'd0;
                    cnt_q <= fl_q;
                    bit_q <= bit_q + 4'd1;
                    if (bit_q != 4'd8) begin
                        rxsh_q <= {rxsh_q[6:0], sda_f};
                        sh_q <= {sh_q[7:0], 1'b1};
                        sda_oe_q <= ~sh_q[7];
                    end else if (addr_nack || (data_end && (stop_now || cur_stop_q))) begin
                        state_q <= ST_STOP;
                        sda_oe_q <= 1'b1;
                    end else if (phase_q == PH_HDR && tar_q[`I2CM_TAR_TEN]) begin
                        phase_q <= PH_LO;
                        bit_q <= 4'd0;
                        sh_q <= {tar_q[7:0], 1'b1};
                        sda_oe_q <= ~tar_q[7];
                    end else if (phase_q != PH_DATA) begin
                        state_q <= stop_now ? ST_STOP : ST_BIT;
                        phase_q <= PH_DATA;
                        bit_q <= 4'd0;
                        sh_q <= byte_of({cur_stop_q, cur_rw_q, cur_data_q});
                        sda_oe_q <= stop_now | (~cur_rw_q & ~cur_data_q[7]);
                    end else if (go_next && next_rw == cur_rw_q) begin
                        bit_q <= 4'd0;
                        sh_q <= next_byte;
                        sda_oe_q <= ~next_byte[8];
                    end else if (go_next) begin
                        state_q <= ST_START; // Direction change needs a repeated start
                        step_q <= 2'd0;
                        sda_oe_q <= 1'b0;
                    end else if (stop_now || !EMPTY_QUEUE_HOLD) begin
                        state_q <= ST_STOP;
                        sda_oe_q <= 1'b1;
                    end else begin
                        state_q <= ST_HOLD;
                        sda_oe_q <= 1'b0;
                    end
                end
                ST_HOLD: begin
                    cnt_q <= fl_q;
                    if (stop_now) begin
                        state_q <= ST_STOP;
                        sda_oe_q <= 1'b1;
                    end else if (go_next && next_rw == cur_rw_q) begin
                        state_q <= ST_BIT;
                        step_q <= 2'd0;
                        bit_q <= 4'd0;
                        sh_q <= next_byte;
                        sda_oe_q <= ~next_byte[8];
                    end else if (go_next) begin
                        state_q <= ST_START;
                        step_q <= 2'd0;
                    end
                end
                ST_STOP: if (tick) begin
                    cnt_q <= fh_q;
                    step_q <= step_q + 2'd1;
                    if (step_q == 2'd0) scl_oe_q <= 1'b0;
                    if (step_q == 2'd1) sda_oe_q <= 1'b0;
                    if (step_q == 2'd2) begin
                        state_q <= ST_IDLE;
                        step_q <= 2'd0;
                    end
                end
            endcase
        end
    end

    // SDA moves one cycle after SCL falls, so a data change never looks like start or stop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sda_hold_q <= 1'b0;
        end else begin
            sda_hold_q <= sda_oe_q;
        end
    end

    // Open-drain pins: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_hold_q;
    assign state = state_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_tar_locked;
        @(posedge ref_clk) disable iff (rst) (en_q && wr && hit_tar) |=>
            tar_q == (LIVE_TARGET_REWRITE ? $past(pwdata[12:0]) : $past(tar_q));
    endproperty
    a_tar_locked: assert property (p_tar_locked) else $error("target write mishandled while enabled");

    property p_spk_locked;
        @(posedge ref_clk) disable iff (rst) (en_q && wr && (hit_sf || hit_hs)) |=> ($stable(spk_sf_q) && $stable(spk_hs_q));
    endproperty
    a_spk_locked: assert property (p_spk_locked) else $error("filter limit written while enabled");

    property p_spk_min;
        @(posedge ref_clk) disable iff (rst) (!en_q && wr && hit_sf && pwdata[7:0] == 8'h00) |=> spk_sf_q == 8'h01;
    endproperty
    a_spk_min: assert property (p_spk_min) else $error("zero filter limit stored");

    property p_en_write;
        @(posedge ref_clk) disable iff (rst) (wr && hit_en) |=> en_q == $past(pwdata[0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable bit not taken");

    property p_en_status;
        @(posedge ref_clk) disable iff (rst) (setup && !pwrite && hit_ens && busy) |=> prdata_q[0];
    endproperty
    a_en_status: assert property (p_en_status) else $error("enable-state dropped while busy");

    property p_hold_low;
        @(posedge ref_clk) disable iff (rst) (state_q == ST_HOLD && !stop_now && !buf_out_valid) |=> scl_oe;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("SCL released while holding");

    sequence s_abort_idle;
        abort_q && state_q == ST_IDLE;
    endsequence
    property p_abort_flush;
        @(posedge ref_clk) disable iff (rst) s_abort_idle |=> (!abort_q && !buf_out_valid && abn_q[1]);
    endproperty
    a_abort_flush: assert property (p_abort_flush) else $error("abort did not flush");

    property p_disabled_empty;
        @(posedge ref_clk) disable iff (rst) !en_q |=> !buf_out_valid;
    endproperty
    a_disabled_empty: assert property (p_disabled_empty) else $error("queue kept while disabled");

    property p_start_run;
        @(posedge ref_clk) disable iff (rst) go_idle |=> (state_q == ST_START && busy);
    endproperty
    a_start_run: assert property (p_start_run) else $error("queued command not started");
endmodule

// ---- bench/i2cm_tgt_model.sv ----
// Behavioural two-wire target that acknowledges every byte it sees
`timescale 1ns/1ps
module i2cm_tgt_model (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    int bitn = 0;
    initial sda_pull = 1'b0;
    // Start or stop while clock is high restarts the bit count
    always @(sda) if (scl) bitn = 0;
    always @(posedge scl) bitn = bitn + 1;
    // Pull only in the ack slot; released data line floats high
    always @(negedge scl) sda_pull <= (bitn % 9 == 8);
endmodule

// ---- bench/i2cm_ctrl_tb.sv ----
// Self-checking bench for the two-wire master controller
`timescale 1ns/1ps
`include "i2cm_map.svh"
module i2cm_ctrl_tb;
    import i2cm_pkg::*;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, sda_pull, pready, pslverr;
    logic [7:0] paddr = 8'h00, sh = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic scl_o, scl_oe, sda_o, sda_oe;
    i2cm_state_type state;
    int num_errors = 0, n_checks = 0, cyc = 0, nbit = 0;
    logic [7:0] seen[$];
    // Open-drain lines with pull-ups
    wire scl_w = !scl_oe;
    wire sda_w = !(sda_oe || sda_pull);
    always #2 ref_clk = ~ref_clk;
    i2cm_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .state(state));
    i2cm_tgt_model u_tgt (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull));
    // Monitor: bytes gathered MSB first, ack slot dropped
    always @(sda_w) if (scl_w) nbit = 0;
    always @(posedge scl_w) begin
        sh = {sh[6:0], sda_w};
        nbit++;
        if (nbit % 9 == 8) seen.push_back(sh);
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; idle cycle after so strobes never toggle twice
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Ready judged mid-cycle, so a fill at the completing edge is not mistaken for a stall
        do @(negedge ref_clk); while (pready !== 1'b1);
        @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Bounded poll of one register bit
    task poll(input logic [7:0] a, input int b, input logic v);
        repeat (3000) begin
            apb(1'b0, a, 32'h0);
            if (rd[b] === v) break;
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc == 90000) begin
        num_errors++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, `I2CM_OFF_SPK_SF, 32'h0);
        chk("spike_sf_reset", 32'h05, rd);
        apb(1'b1, `I2CM_OFF_SPK_SF, 32'h0);
        apb(1'b0, `I2CM_OFF_SPK_SF, 32'h0);
        chk("spike_sf_min", 32'h01, rd);
        apb(1'b1, `I2CM_OFF_SPK_HS, 32'h03);
        apb(1'b0, `I2CM_OFF_SPK_HS, 32'h0);
        chk("spike_hs_rw", 32'h03, rd);
        apb(1'b1, `I2CM_OFF_CTRL, 32'h7D);
        apb(1'b1, `I2CM_OFF_FHCNT, 32'h10);
        apb(1'b1, `I2CM_OFF_FLCNT, 32'h10);
        apb(1'b1, `I2CM_OFF_CMD, 32'h0AA);
        apb(1'b1, `I2CM_OFF_ENABLE, 32'h1);
        apb(1'b0, `I2CM_OFF_EN_STAT, 32'h0);
        chk("en_status_on", 32'h1, rd);
        apb(1'b0, `I2CM_OFF_STATUS, 32'h0);
        chk("queue_empty", 32'h1, rd[2]);
        apb(1'b1, `I2CM_OFF_SPK_SF, 32'h9);
        apb(1'b0, `I2CM_OFF_SPK_SF, 32'h0);
        chk("spike_sf_locked", 32'h01, rd);
        apb(1'b1, `I2CM_OFF_TAR, 32'h33);
        apb(1'b0, `I2CM_OFF_TAR, 32'h0);
        chk("target_live", 32'h33, rd);
        apb(1'b1, `I2CM_OFF_CMD, 32'h0A5);
        apb(1'b1, `I2CM_OFF_CMD, 32'h300);
        poll(`I2CM_OFF_STATUS, 5, 1'b0);
        chk("hdr_write", 32'h66, seen[0]);
        chk("data_write", 32'hA5, seen[1]);
        chk("hdr_read", 32'h67, seen[2]);
        chk("stop_idle", ST_IDLE, state);
        apb(1'b0, `I2CM_OFF_CMD, 32'h0);
        chk("rx_byte", 32'hFF, rd);
        apb(1'b1, `I2CM_OFF_CMD, 32'h03C);
        poll(`I2CM_OFF_STATUS, 2, 1'b1);
        repeat (2000) @(posedge ref_clk);
        chk("hdr_write2", 32'h66, seen[4]);
        chk("data_write2", 32'h3C, seen[5]);
        chk("hold_state", ST_HOLD, state);
        chk("scl_held", 32'h0, scl_w);
        apb(1'b1, `I2CM_OFF_ENABLE, 32'h3);
        poll(`I2CM_OFF_ABN_SRC, 1, 1'b1);
        chk("abandon_src", 32'h1, rd[1]);
        chk("scl_after_abort", 32'h1, scl_w);
        apb(1'b1, `I2CM_OFF_CMD, 32'h255);
        apb(1'b1, `I2CM_OFF_ENABLE, 32'h0);
        apb(1'b0, `I2CM_OFF_EN_STAT, 32'h0);
        chk("en_status_busy", 32'h1, rd[0]);
        poll(`I2CM_OFF_EN_STAT, 0, 1'b0);
        chk("en_status_off", 32'h0, rd[0]);
        apb(1'b0, 8'h44, 32'h0);
        chk("unmapped_err", 32'h1, err);
        complete_run;
    end
endmodule
